// [core/bsl_loader.sv]
`timescale 1ns/1ps
// Summary of operation
// - after reset, software reset checks skip bit 4
// - skip bit set jumps straight to imem
// - processor-type flag picks hand-off start address
// - each block opens with a 10-byte header
// - header is address, count, then flag word
// - zero-fill writes count zeros, reads no body
// - init block loaded, called, then parsing resumes
// - compressed block body holds packed data
// - last block loaded, then jump to imem
// - hand-off keeps supervisor at chosen priority level
// - twi buffer data only in final block
// - stream begins straight with first header
// - flag bits 10:5 name the host pause pin
module bsl_loader
    import bsl_pkg::*;
#(
    parameter int          ADDR_W    = 32,
    parameter logic        LOW_PRIO  = 1'b1
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // boot-time straps and events
    input  wire logic        soft_reset,
    input  wire logic        twi_mode,
    // stream from the boot source
    input  wire logic [7:0]  src_data,
    input  wire logic        src_valid,
    output logic             src_ready,
    output logic             host_pause_pin,
    output logic      [5:0]  host_pause_sel,
    // memory write port
    output logic      [31:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_we,
    input  wire logic        mem_ready,
    // processor hand-off
    output logic             call_req,
    output logic      [31:0] call_addr,
    input  wire logic        call_return,
    output logic             jump_req,
    output logic      [31:0] jump_addr,
    output logic             lowest_priority_level,
    output logic             comp_seen,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    typedef struct packed {
        bsl_state_t  st;
        logic        started;
        logic [31:0] ctrl;
        logic [31:0] reset_config_register;
        logic [31:0] addr;
        logic [31:0] remain;
        logic [15:0] flags;
        logic [15:0] blocks;
        logic        src_ready;
        logic        pause;
        logic [5:0]  pause_sel;
        logic [31:0] mem_addr;
        logic [7:0]  mem_wdata;
        logic        mem_we;
        logic        call_req;
        logic [31:0] call_addr;
        logic        jump_req;
        logic [31:0] jump_addr;
        logic        low_prio;
        logic        comp_seen;
        logic        twi_err;
        logic        ap_valid;
        logic        ap_write;
        logic [7:0]  ap_addr;
        logic [31:0] hrdata;
    } bsl_regs_t;

    bsl_regs_t r;
    bsl_regs_t next_r;

    logic [1:0]  srst_sync;
    logic [1:0]  twi_sync;
    logic        hdr_clear;
    logic        hdr_load;
    logic [31:0] h_addr;
    logic [31:0] h_count;
    logic [15:0] h_flags;
    logic [3:0]  h_nbytes;
    logic        take;
    logic        wr_done;
    logic [31:0] start_addr;
    logic [31:0] status;

    // straps come from another domain, two flops before use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            srst_sync <= 2'b00;
            twi_sync  <= 2'b00;
        end else begin
            srst_sync <= {srst_sync[0], soft_reset};
            twi_sync  <= {twi_sync[0], twi_mode};
        end
    end

    bsl_hdr_shift u_hdr (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clear   (hdr_clear),
        .load    (hdr_load),
        .byte_in (src_data),
        .addr    (h_addr),
        .count   (h_count),
        .flags   (h_flags),
        .nbytes  (h_nbytes)
    );

    assign take     = r.src_ready && src_valid;
    assign wr_done  = r.mem_we && mem_ready;
    assign hdr_load = (r.st == BSL_HDR) && take;
    assign hdr_clear = (r.st == BSL_CHECK) || (r.st == BSL_DECODE);
    // variant group picked per block by the processor-type flag
    assign start_addr = r.flags[FLG_PTYPE_POS] ? IMEM_START_A : IMEM_START_B;
    assign status = {7'h00, r.call_req, r.blocks, r.twi_err, r.comp_seen,
                     r.low_prio, r.jump_req, r.st};

    always_comb begin
        next_r          = r;
        next_r.call_req = r.call_req;
        next_r.hrdata   = r.hrdata;
        // writes complete before anything else touches memory
        if (wr_done) begin
            next_r.mem_we = 1'b0;
        end

        case (r.st)
            BSL_IDLE: begin
                if (!r.started) begin
                    next_r.started = 1'b1;
                    next_r.st      = BSL_CHECK;
                end
            end
            BSL_CHECK: begin
                next_r.low_prio = LOW_PRIO;
                // first decision after reset
                if (srst_sync[1] && r.reset_config_register[SKIP_BOOT_POS]) begin
                    next_r.st = BSL_JUMP;
                end else begin
                    // stream opens with a header, no global prefix
                    next_r.st        = BSL_HDR;
                    next_r.src_ready = 1'b1;
                end
            end
            BSL_HDR: begin
                // exactly ten header bytes per block
                if (take && (h_nbytes == 4'(HDR_BYTES - 1))) begin
                    next_r.src_ready = 1'b0;
                    next_r.st        = BSL_DECODE;
                end
            end
            BSL_DECODE: begin
                next_r.addr      = h_addr;
                next_r.remain    = h_count;
                next_r.flags     = h_flags;
                next_r.blocks    = r.blocks + 16'h1;
                next_r.pause_sel = h_flags[PAUSE_PIN_MSB:PAUSE_PIN_LSB];
                if (h_flags[FLG_COMP_POS]) begin
                    // body passed through unexpanded; decoder lives elsewhere
                    next_r.comp_seen = 1'b1;
                end
                if (twi_sync[1] && !h_flags[FLG_LAST_POS] && h_addr[15:0] >= TWI_BUF_LO[15:0]
                    && h_addr[15:0] <= TWI_BUF_HI[15:0]) begin
                    next_r.twi_err = 1'b1;
                end
                if (h_count == 32'h0) begin
                    next_r.st = BSL_CALL;
                end else if (h_flags[FLG_IGNORE_POS]) begin
                    next_r.st        = BSL_SKIP;
                    next_r.src_ready = !h_flags[FLG_ZERO_POS];
                end else if (h_flags[FLG_ZERO_POS]) begin
                    next_r.st = BSL_ZERO;
                end else begin
                    next_r.st        = BSL_BODY;
                    next_r.src_ready = 1'b1;
                end
            end
            BSL_BODY: begin
                // one byte in flight; stall the source until memory accepts
                if (take) begin
                    next_r.src_ready = 1'b0;
                    next_r.mem_addr  = r.addr;
                    next_r.mem_wdata = src_data;
                    next_r.mem_we    = 1'b1;
                    next_r.addr      = r.addr + 32'h1;
                    next_r.remain    = r.remain - 32'h1;
                end else if (wr_done) begin
                    if (r.remain == 32'h0) begin
                        next_r.st = BSL_CALL;
                    end else begin
                        next_r.src_ready = 1'b1;
                    end
                end
            end
            BSL_ZERO: begin
                if (!r.mem_we) begin
                    next_r.mem_addr  = r.addr;
                    next_r.mem_wdata = 8'h00;
                    next_r.mem_we    = 1'b1;
                    next_r.addr      = r.addr + 32'h1;
                    next_r.remain    = r.remain - 32'h1;
                end else if (wr_done && r.remain == 32'h0) begin
                    next_r.st = BSL_CALL;
                end
            end
            BSL_SKIP: begin
                if (r.flags[FLG_ZERO_POS] || (take && r.remain == 32'h1)) begin
                    next_r.src_ready = 1'b0;
                    next_r.remain    = 32'h0;
                    next_r.st        = BSL_CALL;
                end else if (take) begin
                    next_r.remain = r.remain - 32'h1;
                end
            end
            BSL_CALL: begin
                // block finished: dispatch init call, hand-off, or next header
                if (r.flags[FLG_INIT_POS] && !r.flags[FLG_IGNORE_POS]) begin
                    if (!r.call_req) begin
                        next_r.call_req  = 1'b1;
                        next_r.call_addr = r.addr - r.remain - h_count;
                    end else if (call_return) begin
                        // code must return by itself, no timeout here
                        next_r.call_req = 1'b0;
                        next_r.flags    = r.flags & ~(16'h1 << FLG_INIT_POS);
                    end
                end else if (r.flags[FLG_LAST_POS]) begin
                    next_r.st = BSL_JUMP;
                end else begin
                    next_r.st        = BSL_HDR;
                    next_r.src_ready = 1'b1;
                end
            end
            BSL_JUMP: begin
                next_r.jump_req  = 1'b1;
                next_r.jump_addr = start_addr;
                next_r.st        = BSL_DONE;
            end
            BSL_DONE: begin
                next_r.jump_req = 1'b1;
            end
            default: begin
                next_r.st = BSL_IDLE;
            end
        endcase

        // ahb data phase of a captured write
        if (r.ap_valid && r.ap_write) begin
            if (r.ap_addr == REG_CTRL) begin
                next_r.ctrl = hwdata;
            end else if (r.ap_addr == REG_RESET_CFG) begin
                next_r.reset_config_register = hwdata;
            end
        end
        // ahb address phase
        next_r.ap_valid = hsel && hready && htrans[1];
        next_r.ap_write = hwrite;
        next_r.ap_addr  = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == REG_CTRL) begin
                next_r.hrdata = r.ctrl;
            end else if (haddr[7:0] == REG_STATUS) begin
                next_r.hrdata = status;
            end else if (haddr[7:0] == REG_RESET_CFG) begin
                next_r.hrdata = r.reset_config_register;
            end else if (haddr[7:0] == REG_HANDOFF) begin
                next_r.hrdata = r.jump_addr;
            end else if (haddr[7:0] == REG_FLAGS) begin
                next_r.hrdata = {16'h0, r.flags};
            end else if (haddr[7:0] == REG_BLOCKS) begin
                next_r.hrdata = {16'h0, r.blocks};
            end else begin
                next_r.hrdata = 32'h0;
            end
        end
        // ctrl bit 0 restarts the sequence at the check state, only once the loader is done
        if (r.ctrl[0] && r.st == BSL_DONE) begin
            next_r.st       = BSL_CHECK;
            next_r.jump_req = 1'b0;
            next_r.blocks   = 16'h0;
            next_r.ctrl     = r.ctrl & ~32'h1;
        end
        // last, so a restart out of done pauses the host at once
        next_r.pause = (next_r.st != BSL_DONE) && !next_r.src_ready;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r                       <= '0;
            r.st                    <= BSL_IDLE;
            r.ctrl                  <= CTRL_RESET;
            r.reset_config_register <= RESET_CFG_RESET;
            r.pause                 <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign src_ready             = r.src_ready;
    assign host_pause_pin        = r.pause;
    assign host_pause_sel        = r.pause_sel;
    assign mem_addr              = r.mem_addr;
    assign mem_wdata             = r.mem_wdata;
    assign mem_we                = r.mem_we;
    assign call_req              = r.call_req;
    assign call_addr             = r.call_addr;
    assign jump_req              = r.jump_req;
    assign jump_addr             = r.jump_addr;
    assign lowest_priority_level = r.low_prio;
    assign comp_seen             = r.comp_seen;
    assign hrdata                = r.hrdata;
    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
endmodule // bsl_loader

// [core/bsl_pkg.sv]
package bsl_pkg;
    localparam int          HDR_BYTES         = 10;
    localparam int          ADDR_BYTES        = 4;
    localparam int          CNT_BYTES         = 4;
    localparam int          FLAG_BYTES        = 2;
    localparam int          SKIP_BOOT_POS     = 4;
    localparam logic [31:0] IMEM_START_A      = 32'hffa0_0000;
    localparam logic [31:0] IMEM_START_B      = 32'hffa0_8000;
    localparam logic [31:0] TWI_BUF_LO        = 32'h0000_3f00;
    localparam logic [31:0] TWI_BUF_HI        = 32'h0000_3fff;
    localparam int          PAUSE_PIN_LSB     = 5;
    localparam int          PAUSE_PIN_MSB     = 10;
    localparam int          FLG_ZERO_POS      = 0;
    localparam int          FLG_PTYPE_POS     = 1;
    localparam int          FLG_INIT_POS      = 3;
    localparam int          FLG_IGNORE_POS    = 4;
    localparam int          FLG_COMP_POS      = 13;
    localparam int          FLG_LAST_POS      = 15;
    localparam logic [7:0]  REG_CTRL          = 8'h00;
    localparam logic [7:0]  REG_STATUS        = 8'h04;
    localparam logic [7:0]  REG_RESET_CFG     = 8'h08;
    localparam logic [7:0]  REG_HANDOFF       = 8'h0c;
    localparam logic [7:0]  REG_FLAGS         = 8'h10;
    localparam logic [7:0]  REG_BLOCKS        = 8'h14;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [31:0] RESET_CFG_RESET   = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'b10;

    typedef enum logic [3:0] {
        BSL_IDLE   = 4'b0000,
        BSL_CHECK  = 4'b0001,
        BSL_HDR    = 4'b0011,
        BSL_DECODE = 4'b0010,
        BSL_BODY   = 4'b0110,
        BSL_ZERO   = 4'b0111,
        BSL_SKIP   = 4'b0101,
        BSL_CALL   = 4'b0100,
        BSL_JUMP   = 4'b1100,
        BSL_DONE   = 4'b1101
    } bsl_state_t;
endpackage

// [core/bsl_hdr_shift.sv]
`timescale 1ns/1ps
// lsb-first byte assembler for the 10-byte block header
module bsl_hdr_shift
    import bsl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clear,
    input  wire logic        load,
    input  wire logic [7:0]  byte_in,
    output logic      [31:0] addr,
    output logic      [31:0] count,
    output logic      [15:0] flags,
    output logic      [3:0]  nbytes
);
    logic [79:0] hdr;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hdr    <= 80'h0;
            nbytes <= 4'h0;
        end else if (clear) begin
            nbytes <= 4'h0;
        end else if (load) begin
            // later bytes enter at the top, so byte 0 ends lowest
            hdr    <= {byte_in, hdr[79:8]};
            nbytes <= nbytes + 4'h1;
        end
    end

    // address, then count, then flag word
    assign addr  = hdr[31:0];
    assign count = hdr[63:32];
    assign flags = hdr[79:64];
endmodule // bsl_hdr_shift

// [tb/bsl_loader_props.sv]
`timescale 1ns/1ps
module bsl_loader_props
    import bsl_pkg::*;
#(
    parameter logic LOW_PRIO = 1'b1
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        src_ready,
    input  wire logic        host_pause_pin,
    input  wire logic [31:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_ready,
    input  wire logic        call_req,
    input  wire logic [31:0] call_addr,
    input  wire logic        call_return,
    input  wire logic        jump_req,
    input  wire logic [31:0] jump_addr,
    input  wire logic        lowest_priority_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_pause; !src_ready && !jump_req |-> host_pause_pin; endproperty
    a_pause: assert property (p_pause) else $error("pause pin low while held off");
    property p_we_hold;
        mem_we && !mem_ready |=> mem_we && $stable(mem_addr) && $stable(mem_wdata);
    endproperty
    a_we_hold: assert property (p_we_hold) else $error("write dropped early");
    property p_call_hold; call_req && !call_return |=> call_req && $stable(call_addr); endproperty
    a_call_hold: assert property (p_call_hold) else $error("call dropped early");
    property p_call_quiet; call_req |-> !src_ready && !mem_we; endproperty
    a_call_quiet: assert property (p_call_quiet) else $error("parsing during call");
    property p_jump_addr;
        jump_req |-> jump_addr == IMEM_START_A || jump_addr == IMEM_START_B;
    endproperty
    a_jump_addr: assert property (p_jump_addr) else $error("bad hand-off address");
    property p_jump_quiet; jump_req |-> !src_ready && !mem_we && !call_req; endproperty
    a_jump_quiet: assert property (p_jump_quiet) else $error("activity after hand-off");
    property p_jump_stable; jump_req |=> !jump_req || $stable(jump_addr); endproperty
    a_jump_stable: assert property (p_jump_stable) else $error("hand-off moved");
    property p_prio; jump_req |-> lowest_priority_level == LOW_PRIO; endproperty
    a_prio: assert property (p_prio) else $error("wrong priority level");

    c_call: cover property (call_req && call_return);
    c_stall: cover property (mem_we && !mem_ready);
    c_jump: cover property ($rose(jump_req));
endmodule // bsl_loader_props

bind bsl_loader bsl_loader_props #(.LOW_PRIO(LOW_PRIO)) u_props (
    .clk, .sys_rst, .src_ready, .host_pause_pin, .mem_addr, .mem_wdata, .mem_we,
    .mem_ready, .call_req, .call_addr, .call_return, .jump_req, .jump_addr,
    .lowest_priority_level
);

// [tb/bsl_src_model.sv]
`timescale 1ns/1ps
module bsl_src_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       slow,
    output logic      [7:0] src_data,
    output logic            src_valid,
    input  wire logic       src_ready
);
    logic [7:0] q[$];
    logic       gap;

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    // a byte stands until taken; slow mode leaves a gap every other cycle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_valid <= 1'b0;
            src_data  <= 8'ha5;
            gap       <= 1'b0;
        end else begin
            gap <= ~gap;
            if (src_valid && !src_ready) begin
                src_valid <= 1'b1;
            end else if (q.size() > 0 && !(slow && gap)) begin
                src_valid <= 1'b1;
                src_data  <= q.pop_front();
            end else begin
                src_valid <= 1'b0;
                src_data  <= ~src_data; // no stale byte on an idle line
            end
        end
    end
endmodule // bsl_src_model

// [tb/test_bsl_loader.sv]
`timescale 1ns/1ps
module test_bsl_loader;
    import bsl_pkg::*;
    logic        clk = 0, sys_rst = 1, soft_reset = 0, twi_mode = 0, slow = 0;
    logic        mem_ready = 0, call_return = 0, hsel = 0, hwrite = 0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [7:0]  src_data, mem_wdata;
    logic        src_valid, src_ready, host_pause_pin, mem_we, call_req, jump_req;
    logic        lowest_priority_level, comp_seen, hreadyout, hresp;
    logic [5:0]  host_pause_sel;
    logic [31:0] mem_addr, call_addr, jump_addr, hrdata;
    logic [39:0] got_q[$], exp_q[$];
    int          err_count = 0, checked = 0, calls = 0;

    always #2.5 clk = ~clk;

    bsl_loader #(.LOW_PRIO(1'b1)) uut (
        .clk, .sys_rst, .soft_reset, .twi_mode, .src_data, .src_valid, .src_ready,
        .host_pause_pin, .host_pause_sel, .mem_addr, .mem_wdata, .mem_we, .mem_ready,
        .call_req, .call_addr, .call_return, .jump_req, .jump_addr,
        .lowest_priority_level, .comp_seen, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp
    );

    bsl_src_model src (.clk, .sys_rst, .slow, .src_data, .src_valid, .src_ready);

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    // memory stalls every other cycle; init code returns one cycle after the call
    always @(posedge clk) begin
        mem_ready <= ~mem_ready;
        call_return <= call_req & ~call_return;
        if (mem_we && mem_ready) got_q.push_back({mem_addr, mem_wdata});
        if (call_req && call_return) begin
            calls++;
            chk(call_addr === 32'h0000_3000, "call address");
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk(hresp === 1'b0, "bus response");
    endtask

    function automatic logic [15:0] fl(input int p);
        return 16'h1 << p;
    endfunction

    task automatic blk(input logic [31:0] a, input logic [31:0] n, input logic [15:0] f,
                       input logic [7:0] s);
        logic [79:0] h;
        h = {f, n, a};
        for (int i = 0; i < HDR_BYTES; i++) src.push(h[8*i +: 8]);
        for (int i = 0; i < n; i++) begin
            if (!f[FLG_ZERO_POS]) src.push(s + 8'(i));
            if (!f[FLG_IGNORE_POS])
                exp_q.push_back({a + 32'(i), f[FLG_ZERO_POS] ? 8'h00 : s + 8'(i)});
        end
    endtask

    task automatic settle_cmp;
        int t;
        t = 0;
        while ((got_q.size() != exp_q.size() || jump_req !== 1'b1) && t < 4000) begin
            @(posedge clk);
            t++;
        end
        repeat (4) @(posedge clk);
        chk(got_q.size() == exp_q.size(), "write count");
        foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i] === exp_q[i], "write");
        got_q = {};
        exp_q = {};
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #300000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, REG_CTRL, 32'h0, rd);
        chk(rd === CTRL_RESET, "ctrl reset value");
        bus(1'b0, REG_RESET_CFG, 32'h0, rd);
        chk(rd === RESET_CFG_RESET, "cfg reset value");
        bus(1'b1, 8'h40, 32'hffff_ffff, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk(rd === 32'h0, "unmapped read");
        $display("test registers done");
        slow <= 1'b1;
        blk(32'h1000, 3, 16'h0, 8'h11);
        blk(32'h2000, 2, fl(FLG_ZERO_POS), 8'h22);
        blk(32'h2800, 2, fl(FLG_IGNORE_POS), 8'h33);
        blk(32'h3000, 1, fl(FLG_INIT_POS), 8'h44);
        blk(32'h4000, 2, fl(FLG_LAST_POS) | fl(FLG_COMP_POS) | fl(FLG_PTYPE_POS)
            | {5'h0, 6'h2a, 5'h0}, 8'h55);
        settle_cmp;
        chk(calls == 1, "call count");
        chk(jump_addr === IMEM_START_A, "hand-off address");
        chk(comp_seen === 1'b1, "compressed seen");
        chk(host_pause_sel === 6'h2a, "pause pin select");
        chk(lowest_priority_level === 1'b1, "priority level");
        bus(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd[6:4] === 3'b111, "status flags");
        $display("test stream done");
        slow <= 1'b0;
        soft_reset <= 1'b1;
        bus(1'b1, REG_RESET_CFG, 32'h10, rd);
        bus(1'b0, REG_RESET_CFG, 32'h0, rd);
        chk(rd === 32'h10, "cfg readback");
        bus(1'b1, REG_CTRL, 32'h1, rd);
        repeat (20) @(posedge clk);
        chk(jump_req === 1'b1 && src_ready === 1'b0, "skip boot");
        chk(got_q.size() == 0, "skip wrote memory");
        bus(1'b0, REG_BLOCKS, 32'h0, rd);
        chk(rd === 32'h0, "skip parsed blocks");
        bus(1'b0, REG_CTRL, 32'h0, rd);
        chk(rd === 32'h0, "restart bit cleared");
        $display("test skip done");
        twi_mode <= 1'b1;
        bus(1'b1, REG_RESET_CFG, 32'h0, rd);
        bus(1'b1, REG_CTRL, 32'h1, rd);
        blk(32'h3f10, 1, 16'h0, 8'h66);
        blk(32'h5000, 1, fl(FLG_LAST_POS), 8'h77);
        settle_cmp;
        chk(jump_addr === IMEM_START_B, "hand-off address");
        bus(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd[7] === 1'b1, "buffer overlap flag");
        $display("test full boot done");
        finish_test;
    end
endmodule // test_bsl_loader
